// >>> inc/dmc_map.vh
// How it works
// - read command 0x1/0x9, address high word first
// - bus attributes copied from attribute register fields
// - word clears bit 0, longword bits 1:0
// - byte/word one result word, longword two
// - read bus error answers 0x0001, status set
// - write command 0x1/0x8, address, then data
// - write done 0xFFFF; bus error 0x0001 status
// - block read needs a single read first
// - pointer advances by 1, 2 or 4
// - block read only after no-op/read/block read
// - size field decoded on every block read
// - block read 0xD, no operands, read format
// - size bits 7:6: byte, word, longword, reserved
// - status set for illegal, not-ready, bus error
// - transfers during memory access get not-ready
`ifndef DMC_MAP_VH
`define DMC_MAP_VH
`define DMC_CLASS_MEM    4'h1
`define DMC_OP_READ      4'h9
`define DMC_OP_WRITE     4'h8
`define DMC_OP_DUMP      4'hD
`define DMC_PAD_WORD     16'h0000
`define DMC_SZ_BYTE      2'b00
`define DMC_SZ_WORD      2'b01
`define DMC_SZ_LONG      2'b10
`define DMC_SZ_RSVD      2'b11
`define DMC_F_CLASS      15:12
`define DMC_F_OP         11:8
`define DMC_F_SIZE       7:6
`define DMC_RESP_DONE    16'hFFFF
`define DMC_RESP_BERR    16'h0001
`define DMC_RESP_ILLEGAL 16'hFFFF
`define DMC_RESP_NOTRDY  16'h0000
`define DMC_FIFO_DEPTH   32
`define DMC_FIFO_AW      5
`endif

// >>> design/dmc_fifo.v
`timescale 1ns/1ps
`default_nettype none
module dmc_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 32,
  parameter AW    = 5
)(
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;

  always @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  // pointers wrap through the index math; depth must be a power of two
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push & ~pop)
        count_r <= count_r + 1'b1;
      else if (pop & ~push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule // dmc_fifo
`default_nettype wire

// >>> design/dmc_mem_cmd.v
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.vh"
module dmc_mem_cmd #(
  parameter TYPE_W     = 2,
  parameter MOD_W      = 3,
  parameter FIFO_DEPTH = `DMC_FIFO_DEPTH,
  parameter FIFO_AW    = `DMC_FIFO_AW
)(
  input  wire              CLK_I,
  input  wire              SYS_RST_I,
  input  wire              XFER_VALID_I,
  input  wire [15:0]       XFER_WORD_I,
  output reg               RESP_VALID_O,
  output reg               RESP_STAT_O,
  output reg  [15:0]       RESP_WORD_O,
  input  wire [TYPE_W-1:0] ATTR_TYPE_I,
  input  wire [MOD_W-1:0]  ATTR_MOD_I,
  output reg               MEM_REQ_O,
  output reg               MEM_WR_O,
  output reg  [31:0]       MEM_ADDR_O,
  output reg  [1:0]        MEM_SIZE_O,
  output reg  [TYPE_W-1:0] MEM_TYPE_O,
  output reg  [MOD_W-1:0]  MEM_MOD_O,
  output reg  [31:0]       MEM_WDATA_O,
  input  wire              MEM_ACK_I,
  input  wire              MEM_BERR_I,
  input  wire [31:0]       MEM_RDATA_I
);
  // command phases; S_PUSH drains results into the queue
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_AHI  = 3'd1;
  localparam [2:0] S_ALO  = 3'd2;
  localparam [2:0] S_DHI  = 3'd3;
  localparam [2:0] S_DLO  = 3'd4;
  localparam [2:0] S_MEM  = 3'd5;
  localparam [2:0] S_PUSH = 3'd6;

  reg  [2:0]  state_r;
  reg         wr_r;
  reg  [1:0]  size_r;
  reg  [31:0] addr_r;
  reg  [31:0] wdata_r;
  // block-read pointer; only reads and block reads move it
  reg  [31:0] ptr_r;
  reg         dump_ok_r;
  reg  [16:0] q0_r;
  reg  [16:0] q1_r;
  reg  [1:0]  q_cnt_r;

  wire        busy;
  wire        xfer_idle;
  wire [3:0]  w_class;
  wire [3:0]  w_op;
  wire [1:0]  w_size;
  wire        mem_cmd;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [16:0] fifo_out_data;
  wire        fifo_pop;
  wire        mem_done;

  reg         issue;
  reg  [31:0] issue_addr;
  reg  [1:0]  issue_size;
  reg  [31:0] issue_wdata;

  // address forced to the operand's natural alignment
  function [31:0] align;
    input [31:0] a;
    input [1:0]  sz;
    begin
      case (sz)
        `DMC_SZ_WORD: align = {a[31:1], 1'b0};
        `DMC_SZ_LONG: align = {a[31:2], 2'b00};
        default:      align = a;
      endcase
    end
  endfunction

  // pointer increment per operand size
  function [31:0] step;
    input [1:0] sz;
    begin
      case (sz)
        `DMC_SZ_WORD: step = 32'h0000_0002;
        `DMC_SZ_LONG: step = 32'h0000_0004;
        default:      step = 32'h0000_0001;
      endcase
    end
  endfunction

  // queue pushes count as busy so answers keep their order
  assign busy      = (state_r == S_MEM) | (state_r == S_PUSH);
  assign xfer_idle = XFER_VALID_I & ~busy;
  assign w_class   = XFER_WORD_I[`DMC_F_CLASS];
  assign w_op      = XFER_WORD_I[`DMC_F_OP];
  assign w_size    = XFER_WORD_I[`DMC_F_SIZE];
  assign mem_cmd   = (w_class == `DMC_CLASS_MEM) & (w_size != `DMC_SZ_RSVD);
  assign fifo_pop  = xfer_idle & fifo_out_valid;
  // bus error ends the access just like an acknowledge
  assign mem_done  = MEM_REQ_O & (MEM_ACK_I | MEM_BERR_I);

  // results queue toward the serial side; the engine waits while it is full
  dmc_fifo #(
    .WIDTH (17),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_resp_fifo (
    .clk_i       (CLK_I),
    .rst_i       (SYS_RST_I),
    .in_valid_i  (state_r == S_PUSH),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (q0_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  // decide when a memory cycle starts and with what
  always @*
  begin
    issue       = 1'b0;
    issue_addr  = addr_r;
    issue_size  = size_r;
    issue_wdata = wdata_r;
    if (XFER_VALID_I)
    begin
      case (state_r)
        S_IDLE:
        begin
          if (mem_cmd & (w_op == `DMC_OP_DUMP) & dump_ok_r)
          begin
            issue      = 1'b1;
            issue_addr = ptr_r;
            issue_size = w_size;
          end
        end
        S_ALO:
        begin
          issue      = ~wr_r;
          issue_addr = {addr_r[31:16], XFER_WORD_I};
        end
        S_DHI:
        begin
          issue = 1'b0;
        end
        S_DLO:
        begin
          issue = 1'b1;
          if (size_r == `DMC_SZ_LONG)
            issue_wdata = {wdata_r[31:16], XFER_WORD_I};
          else if (size_r == `DMC_SZ_WORD)
            issue_wdata = {16'h0000, XFER_WORD_I};
          else
            issue_wdata = {24'h00_0000, XFER_WORD_I[7:0]};
        end
        default:
        begin
          issue = 1'b0;
        end
      endcase
    end
  end

  always @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      state_r     <= S_IDLE;
      wr_r        <= 1'b0;
      size_r      <= `DMC_SZ_BYTE;
      addr_r      <= 32'h0000_0000;
      wdata_r     <= 32'h0000_0000;
      ptr_r       <= 32'h0000_0000;
      dump_ok_r   <= 1'b0;
      q0_r        <= 17'h0_0000;
      q1_r        <= 17'h0_0000;
      q_cnt_r     <= 2'd0;
      MEM_REQ_O   <= 1'b0;
      MEM_WR_O    <= 1'b0;
      MEM_ADDR_O  <= 32'h0000_0000;
      MEM_SIZE_O  <= `DMC_SZ_BYTE;
      MEM_TYPE_O  <= {TYPE_W{1'b0}};
      MEM_MOD_O   <= {MOD_W{1'b0}};
      MEM_WDATA_O <= 32'h0000_0000;
    end
    else
    begin
      if (issue)
      begin
        state_r     <= S_MEM;
        MEM_REQ_O   <= 1'b1;
        MEM_WR_O    <= wr_r & (state_r != S_IDLE);
        MEM_ADDR_O  <= align(issue_addr, issue_size);
        MEM_SIZE_O  <= issue_size;
        MEM_TYPE_O  <= ATTR_TYPE_I;
        MEM_MOD_O   <= ATTR_MOD_I;
        MEM_WDATA_O <= issue_wdata;
        size_r      <= issue_size;
        if (state_r == S_IDLE)
          wr_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          S_IDLE:
          begin
            if (XFER_VALID_I)
            begin
              size_r <= w_size;
              if (XFER_WORD_I == `DMC_PAD_WORD)
              begin
                // pointer and block-read permission survive padding
                q0_r    <= {1'b0, `DMC_RESP_DONE};
                q_cnt_r <= 2'd1;
                state_r <= S_PUSH;
              end
              else if (mem_cmd & ((w_op == `DMC_OP_READ) | (w_op == `DMC_OP_WRITE)))
              begin
                wr_r      <= (w_op == `DMC_OP_WRITE);
                dump_ok_r <= 1'b0;
                state_r   <= S_AHI;
              end
              else
              begin
                // block read without a valid predecessor lands here too
                q0_r      <= {1'b1, `DMC_RESP_ILLEGAL};
                q_cnt_r   <= 2'd1;
                dump_ok_r <= 1'b0;
                state_r   <= S_PUSH;
              end
            end
          end
          S_AHI:
          begin
            if (XFER_VALID_I)
            begin
              addr_r[31:16] <= XFER_WORD_I;
              state_r       <= S_ALO;
            end
          end
          S_ALO:
          begin
            if (XFER_VALID_I)
            begin
              addr_r[15:0] <= XFER_WORD_I;
              state_r      <= (size_r == `DMC_SZ_LONG) ? S_DHI : S_DLO;
            end
          end
          S_DHI:
          begin
            if (XFER_VALID_I)
            begin
              wdata_r[31:16] <= XFER_WORD_I;
              state_r        <= S_DLO;
            end
          end
          S_DLO:
          begin
            // wait for the last data word; the issue path leaves this state
            state_r <= S_DLO;
          end
          S_MEM:
          begin
            // other transfers are answered not-ready meanwhile
            if (mem_done)
            begin
              MEM_REQ_O <= 1'b0;
              state_r   <= S_PUSH;
              q_cnt_r   <= 2'd1;
              if (MEM_BERR_I)
                q0_r <= {1'b1, `DMC_RESP_BERR};
              else if (MEM_WR_O)
                q0_r <= {1'b0, `DMC_RESP_DONE};
              else if (MEM_SIZE_O == `DMC_SZ_LONG)
              begin
                q0_r    <= {1'b0, MEM_RDATA_I[31:16]};
                q1_r    <= {1'b0, MEM_RDATA_I[15:0]};
                q_cnt_r <= 2'd2;
              end
              else if (MEM_SIZE_O == `DMC_SZ_WORD)
                q0_r <= {1'b0, MEM_RDATA_I[15:0]};
              else
                q0_r <= {1'b0, 8'h00, MEM_RDATA_I[7:0]};
              if (~MEM_WR_O)
              begin
                // advance even after a bus error; address is never checked
                ptr_r     <= MEM_ADDR_O + step(MEM_SIZE_O);
                dump_ok_r <= 1'b1;
              end
            end
          end
          S_PUSH:
          begin
            // a long read pushes twice, high word first
            if (fifo_in_ready)
            begin
              q0_r    <= q1_r;
              q_cnt_r <= q_cnt_r - 2'd1;
              if (q_cnt_r == 2'd1)
                state_r <= S_IDLE;
            end
          end
          default:
          begin
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // one answer per transfer, taken from the queue head
  always @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      RESP_VALID_O <= 1'b0;
      RESP_STAT_O  <= 1'b0;
      RESP_WORD_O  <= 16'h0000;
    end
    else
    begin
      RESP_VALID_O <= XFER_VALID_I;
      if (XFER_VALID_I)
      begin
        if (fifo_pop)
        begin
          RESP_STAT_O <= fifo_out_data[16];
          RESP_WORD_O <= fifo_out_data[15:0];
        end
        else
        begin
          // empty queue and busy engine look alike; the host polls again
          RESP_STAT_O <= 1'b1;
          RESP_WORD_O <= `DMC_RESP_NOTRDY;
        end
      end
    end
  end
endmodule // dmc_mem_cmd
`default_nettype wire

// >>> test/dmc_mem_cmd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_chk #(
  parameter TYPE_W = 2,
  parameter MOD_W  = 3
)(
  input wire logic              CLK_I,
  input wire logic              SYS_RST_I,
  input wire logic              XFER_VALID_I,
  input wire logic              RESP_VALID_O,
  input wire logic              RESP_STAT_O,
  input wire logic [15:0]       RESP_WORD_O,
  input wire logic [TYPE_W-1:0] ATTR_TYPE_I,
  input wire logic [MOD_W-1:0]  ATTR_MOD_I,
  input wire logic              MEM_REQ_O,
  input wire logic [31:0]       MEM_ADDR_O,
  input wire logic [1:0]        MEM_SIZE_O,
  input wire logic [TYPE_W-1:0] MEM_TYPE_O,
  input wire logic [MOD_W-1:0]  MEM_MOD_O,
  input wire logic              MEM_ACK_I,
  input wire logic              MEM_BERR_I
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  sequence s_end;
    MEM_REQ_O && (MEM_ACK_I || MEM_BERR_I);
  endsequence
  sequence s_wait;
    MEM_REQ_O && !MEM_ACK_I && !MEM_BERR_I;
  endsequence
  sequence s_notrdy;
    RESP_VALID_O && RESP_STAT_O && RESP_WORD_O == 16'h0000;
  endsequence
  AST_ANSWER: assert property (XFER_VALID_I |=> RESP_VALID_O)
    else $error("transfer left unanswered");
  AST_QUIET: assert property (!XFER_VALID_I |=> !RESP_VALID_O)
    else $error("answer without transfer");
  AST_BUSY: assert property (XFER_VALID_I && MEM_REQ_O |=> s_notrdy)
    else $error("transfer during access not refused");
  AST_ALIGN_W: assert property (MEM_REQ_O && MEM_SIZE_O == 2'b01 |-> !MEM_ADDR_O[0])
    else $error("word access misaligned");
  AST_ALIGN_L: assert property (MEM_REQ_O && MEM_SIZE_O == 2'b10 |-> MEM_ADDR_O[1:0] == 2'b00)
    else $error("long access misaligned");
  AST_ATTR: assert property ($rose(MEM_REQ_O) |->
    MEM_TYPE_O == $past(ATTR_TYPE_I) && MEM_MOD_O == $past(ATTR_MOD_I))
    else $error("bus attributes not copied");
  AST_HOLD: assert property (s_wait |=> MEM_REQ_O && $stable(MEM_ADDR_O) && $stable(MEM_SIZE_O))
    else $error("access changed before end");
  AST_DROP: assert property (s_end |=> !MEM_REQ_O [*2])
    else $error("request not released");
endmodule // dmc_chk
bind dmc_mem_cmd dmc_chk #(.TYPE_W(TYPE_W), .MOD_W(MOD_W)) u_chk (
  .CLK_I, .SYS_RST_I, .XFER_VALID_I, .RESP_VALID_O, .RESP_STAT_O, .RESP_WORD_O,
  .ATTR_TYPE_I, .ATTR_MOD_I, .MEM_REQ_O, .MEM_ADDR_O, .MEM_SIZE_O, .MEM_TYPE_O,
  .MEM_MOD_O, .MEM_ACK_I, .MEM_BERR_I
);
`default_nettype wire

// >>> test/dmc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_mem_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        berr_on_i,
  output logic             ack_o,
  output logic             berr_o,
  output logic [31:0]      rdata_o
);
  logic [3:0]       cnt_r = 4'h0;
  wire logic [31:0] pat = {addr_i[15:0] ^ 16'h5A5A, ~addr_i[15:0]};
  wire logic        done = req_i && cnt_r == lat_i;
  assign ack_o = done && !berr_on_i;
  assign berr_o = done && berr_on_i;
  // data moves off the ack so a late sample shows up
  assign rdata_o = ack_o ? pat : ~pat ^ {28'h000_0000, cnt_r};
  always @(posedge clk_i)
    cnt_r <= (req_i && !done) ? cnt_r + 4'h1 : 4'h0;
endmodule // dmc_mem_model
`default_nettype wire

// >>> test/dmc_mem_cmd_test.sv
`timescale 1ns/1ps
`default_nettype none
module dmc_mem_cmd_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        xv = 1'b0;
  logic [15:0] xw = 16'h0000;
  logic        rv, rs, req, wr, ack, berr;
  logic [15:0] rw;
  logic [1:0]  at_t = 2'b00, size, mtyp;
  logic [2:0]  at_m = 3'b000, mmod;
  logic [31:0] addr, wdata, rdata, cap_d;
  logic        berr_on = 1'b0, perm = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic [31:0] seed = 32'h0000_2c05, ptr = 32'h0000_0000;
  logic [16:0] r;
  logic [16:0] exq[$];
  logic [37:0] cap;
  int          err_total = 0, tests_run = 0, cyc = 0;
  dmc_mem_cmd uut (.CLK_I(clk), .SYS_RST_I(rst), .XFER_VALID_I(xv), .XFER_WORD_I(xw),
    .RESP_VALID_O(rv), .RESP_STAT_O(rs), .RESP_WORD_O(rw), .ATTR_TYPE_I(at_t),
    .ATTR_MOD_I(at_m), .MEM_REQ_O(req), .MEM_WR_O(wr), .MEM_ADDR_O(addr), .MEM_SIZE_O(size),
    .MEM_TYPE_O(mtyp), .MEM_MOD_O(mmod), .MEM_WDATA_O(wdata), .MEM_ACK_I(ack),
    .MEM_BERR_I(berr), .MEM_RDATA_I(rdata));
  dmc_mem_model u_mem (.clk_i(clk), .req_i(req), .addr_i(addr), .lat_i(lat),
    .berr_on_i(berr_on), .ack_o(ack), .berr_o(berr), .rdata_o(rdata));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (req && (ack || berr))
    begin
      cap <= {wr, mmod, mtyp, addr};
      cap_d <= wdata;
    end
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'h5A5A, ~a[15:0]};
  endfunction
  function automatic logic [31:0] aln(input logic [31:0] a, input logic [1:0] s);
    return s == 2'b10 ? {a[31:2], 2'b00} : s == 2'b01 ? {a[31:1], 1'b0} : a;
  endfunction
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [37:0] g, input logic [37:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic [15:0] w);
    @(posedge clk);
    #1;
    xv = 1'b1;
    xw = w;
    @(posedge clk);
    #1;
    xv = 1'b0;
    // the answer stands only in the cycle after the word is taken
    r = {rs, rw};
    chk({37'h0, rv}, 38'h1);
  endtask
  // every accepted word is answered with the oldest queued result
  task automatic hx(input logic [15:0] w);
    logic [16:0] e;
    e = 17'h1_0000;
    if (exq.size() > 0)
      e = exq.pop_front();
    xfer(w);
    chk({21'h0, r}, {21'h0, e});
  endtask
  task automatic pad();
    hx(16'h0000);
    exq.push_back(17'h0_FFFF);
  endtask
  // host keeps polling until the answer is not a refusal
  task automatic poll();
    int n;
    n = 0;
    xfer(16'h0000);
    while (r === 17'h1_0000 && n < 40)
    begin
      xfer(16'h0000);
      n++;
    end
    chk({21'h0, r}, {21'h0, exq.pop_front()});
    exq.push_back(17'h0_FFFF);
    chk({37'h0, req}, 38'h0);
  endtask
  task automatic bad(input logic [15:0] c);
    hx(c);
    chk({37'h0, req}, 38'h0);
    exq.push_back(17'h1_FFFF);
    perm = 1'b0;
  endtask
  task automatic mem_op(input logic [3:0] op, input logic [1:0] s, input logic [31:0] a,
      input logic [31:0] d);
    logic [31:0] ea, v, m;
    ea = aln((op == 4'hD) ? ptr : a, s);
    v = rnd();
    at_t = v[1:0];
    at_m = v[4:2];
    lat = v[8:5];
    hx({4'h1, op, s, 6'h00});
    if (op != 4'hD)
    begin
      hx(a[31:16]);
      hx(a[15:0]);
    end
    if (op == 4'h8 && s == 2'b10)
      hx(d[31:16]);
    if (op == 4'h8)
      hx(d[15:0]);
    v = pat(ea);
    m = s == 2'b10 ? 32'hFFFF_FFFF : s == 2'b01 ? 32'h0000_FFFF : 32'h0000_00FF;
    if (berr_on)
      exq.push_back(17'h1_0001);
    else if (op == 4'h8)
      exq.push_back(17'h0_FFFF);
    else if (s == 2'b10)
    begin
      exq.push_back({1'b0, v[31:16]});
      exq.push_back({1'b0, v[15:0]});
    end
    else
      exq.push_back({1'b0, v[15:0] & m[15:0]});
    poll();
    chk(cap, {op == 4'h8, at_m, at_t, ea});
    if (op == 4'h8)
      chk({6'h0, cap_d & m}, {6'h0, d & m});
    if (op != 4'h8)
      ptr = ea + (m == 32'h0000_00FF ? 32'd1 : m == 32'h0000_FFFF ? 32'd2 : 32'd4);
    perm = (op != 4'h8);
  endtask
  initial
  begin
    int i;
    logic [31:0] u;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    pad();
    bad(16'h1D40);
    $display("dump before read done");
    for (i = 0; i < 3; i++)
    begin
      u = (i + 1) % 3;
      mem_op(4'h9, i[1:0], rnd(), 32'h0);
      pad();
      mem_op(4'hD, i[1:0], 32'h0, 32'h0);
      mem_op(4'hD, u[1:0], 32'h0, 32'h0);
    end
    $display("read and dump done");
    for (i = 0; i < 3; i++)
      mem_op(4'h8, i[1:0], rnd(), rnd());
    bad(16'h1D80);
    $display("writes done");
    berr_on = 1'b1;
    mem_op(4'h9, 2'b10, rnd(), 32'h0);
    mem_op(4'hD, 2'b01, 32'h0, 32'h0);
    mem_op(4'h8, 2'b00, rnd(), rnd());
    berr_on = 1'b0;
    mem_op(4'h9, 2'b01, rnd(), 32'h0);
    bad(16'h1DC0);
    bad(16'h1D40);
    $display("errors and reserved size done");
    for (i = 0; i < 24; i++)
    begin
      u = rnd();
      berr_on = u[6:4] == 3'b000;
      if (u[1:0] == 2'b01)
        mem_op(4'h8, u[3:2] % 3, rnd(), rnd());
      else if (u[1:0] == 2'b10 && perm)
        mem_op(4'hD, u[3:2] % 3, 32'h0, 32'h0);
      else if (u[1:0] == 2'b10)
        bad(16'h1D00);
      else
        mem_op(4'h9, u[3:2] % 3, rnd(), 32'h0);
    end
    berr_on = 1'b0;
    $display("random mix done");
    // a second reset must drop the block-read permission
    rst = 1'b1;
    exq.delete();
    ptr = 32'h0000_0000;
    perm = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({37'h0, rv}, 38'h0);
    pad();
    bad(16'h1D00);
    pad();
    $display("second reset done");
    end_of_test();
  end
endmodule // dmc_mem_cmd_test
`default_nettype wire
